/* rtl/output_compare_pwm_unit.sv */
// Output compare unit with AXI4-Lite registers and interrupt
`timescale 1ns/100ps
`include "oc_pwm_cfg.svh"
module output_compare_pwm_unit
    import oc_pwm_pkg::*;
#(
    parameter logic [2:0] UNIT = `UNIT_INDEX
) (
    input wire logic clk,
    input wire logic rst,
    input wire count_in_type cnt,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [4:0] s_axi_awaddrHi,
    output logic compareOutputPin,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        ctrl_type ctrl;
        logic [31:0] primary;
        logic [31:0] secondary;
        logic [4:0] unitOff;
        logic [1:0] status;
        logic [1:0] enable;
        logic awDone;
        logic wDone;
        logic [4:0] awAddr;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
        logic pin;
        logic irq;
    } state_type;
    state_type s_q, s_d;
    logic corePin, coreFault, coreMatch, gated, run, faultSeen;
    logic [31:0] wr, rd;
    logic rdOk;
    // Module-disable halts the compare engine and forces the pin low; bus, fault capture and fault status still advance, match status does not
    assign gated = s_q.unitOff[UNIT];
    assign run = s_q.ctrl.on && !gated && !(s_q.ctrl.stopIdle && cnt.idle);
    oc_compare_core core (
        .clk(clk),
        .rst(rst),
        .ctrl(s_q.ctrl),
        .run(run),
        .cnt(cnt),
        .primary(s_q.primary),
        .secondary(s_q.secondary),
        .faultClr(1'b0),
        .pin(corePin),
        .fault(coreFault),
        .matchPulse(coreMatch)
    );
    assign faultSeen = coreFault;
    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_d = s_q;
        wr = '0;
        rd = '0;
        rdOk = 1'b1;
        if (s_axi_awvalid && !s_q.awDone) begin
            s_d.awDone = 1'b1;
            s_d.awAddr = {s_axi_awaddrHi[4], s_axi_awaddr};
        end
        if (s_axi_wvalid && !s_q.wDone) begin
            s_d.wDone = 1'b1;
            s_d.wData = s_axi_wdata;
            s_d.wStrb = s_axi_wstrb;
        end
        for (int i = 0; i < 4; i++) begin
            wr[i*8 +: 8] = s_q.wStrb[i] ? s_q.wData[i*8 +: 8] : 8'h00;
        end
        // Sticky events; set beats a simultaneous clear
        if (s_q.awDone && s_q.wDone && !s_q.bValid) begin
            s_d.awDone = 1'b0;
            s_d.wDone = 1'b0;
            s_d.bValid = 1'b1;
            s_d.bResp = `RESP_OKAY;
            case (s_q.awAddr)
                {1'b0, `ADDR_CONTROL}: if (!gated) begin
                    if (s_q.wStrb[1]) begin
                        s_d.ctrl.on = wr[`BIT_ON];
                        s_d.ctrl.stopIdle = wr[`BIT_STOP_IDLE];
                    end
                    if (s_q.wStrb[0]) begin
                        s_d.ctrl.wide = wr[`BIT_WIDE];
                        s_d.ctrl.timerSel = wr[`BIT_TSEL];
                        s_d.ctrl.mode = mode_type'(wr[2:0]);
                    end
                end
                {1'b0, `ADDR_PRIMARY}: if (!gated) begin
                    for (int i = 0; i < 4; i++) begin
                        if (s_q.wStrb[i]) s_d.primary[i*8 +: 8] = wr[i*8 +: 8];
                    end
                end
                {1'b0, `ADDR_SECONDARY}: if (!gated) begin
                    for (int i = 0; i < 4; i++) begin
                        if (s_q.wStrb[i]) s_d.secondary[i*8 +: 8] = wr[i*8 +: 8];
                    end
                end
                {1'b0, `ADDR_DISABLE}: if (s_q.wStrb[2]) begin
                    s_d.unitOff = wr[`DISABLE_LSB +: 5];
                end
                `ADDR_CLEAR: if (s_q.wStrb[0]) s_d.status = s_q.status & ~wr[1:0];
                `ADDR_ENABLE: if (s_q.wStrb[0]) s_d.enable = wr[1:0];
                `ADDR_STATUS: s_d.bResp = `RESP_OKAY;
                default: s_d.bResp = `RESP_SLVERR;
            endcase
        end
        if (s_q.bValid && s_axi_bready) s_d.bValid = 1'b0;
        if (coreMatch) s_d.status[`IRQ_MATCH] = 1'b1;
        if (faultSeen) s_d.status[`IRQ_FAULT] = 1'b1;
        case (s_axi_araddr)
            {1'b0, `ADDR_CONTROL}: begin
                rd[`BIT_ON] = s_q.ctrl.on;
                rd[`BIT_STOP_IDLE] = s_q.ctrl.stopIdle;
                rd[`BIT_WIDE] = s_q.ctrl.wide;
                rd[`BIT_FAULT] = coreFault && s_q.ctrl.mode == MODE_PWM_FAULT;
                rd[`BIT_TSEL] = s_q.ctrl.timerSel;
                rd[2:0] = s_q.ctrl.mode;
            end
            {1'b0, `ADDR_PRIMARY}: rd = s_q.primary;
            {1'b0, `ADDR_SECONDARY}: rd = s_q.secondary;
            {1'b0, `ADDR_DISABLE}: rd[`DISABLE_LSB +: 5] = s_q.unitOff;
            `ADDR_STATUS: rd[1:0] = s_q.status;
            `ADDR_CLEAR: rd = '0;
            `ADDR_ENABLE: rd[1:0] = s_q.enable;
            default: rdOk = 1'b0;
        endcase
        if (s_axi_arvalid && !s_q.rValid) begin
            s_d.rValid = 1'b1;
            s_d.rData = rd;
            s_d.rResp = rdOk ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_q.rValid && s_axi_rready) begin
            s_d.rValid = 1'b0;
        end
        s_d.pin = gated ? 1'b0 : corePin;
        s_d.irq = |(s_d.status & s_d.enable);
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign s_axi_awready = !s_q.awDone;
    assign s_axi_wready = !s_q.wDone;
    assign s_axi_bvalid = s_q.bValid;
    assign s_axi_bresp = s_q.bResp;
    assign s_axi_arready = !s_q.rValid;
    assign s_axi_rvalid = s_q.rValid;
    assign s_axi_rdata = s_q.rData;
    assign s_axi_rresp = s_q.rResp;
    assign compareOutputPin = s_q.pin;
    assign irq = s_q.irq;
endmodule

/* inc/oc_pwm_cfg.svh */
// Constants and register map of the output compare unit
// Operation
// - Unit runs only while enable bit 15 set
// - Stop-in-idle set halts unit in idle mode
// - Wide compare uses full 32-bit values
// - Narrow compare uses low 16 bits only
// - Fault status set by hardware, read-only
// - Fault status reads zero outside mode 111
// - Timer select: one third timer, zero second
// - Modes 111/110 PWM, fault honoured only 111
// - Mode 101 starts low, continuous pulses
// - Mode 100 starts low, one pulse
// - Mode 011 match toggles the pin
// - Mode 010 starts high, match forces low
// - Mode 001 starts low, match forces high
// - Mode 000 compare inactive but clocked
// - Module-disable stops unit, control and compare writes ignored
// - Per-unit disable bits sixteen through twenty
`ifndef OC_PWM_CFG_SVH
`define OC_PWM_CFG_SVH
`define ADDR_CONTROL 4'h0
`define ADDR_PRIMARY 4'h4
`define ADDR_SECONDARY 4'h8
`define ADDR_DISABLE 4'hc
`define ADDR_STATUS 5'h10
`define ADDR_CLEAR 5'h14
`define ADDR_ENABLE 5'h18
`define BIT_ON 15
`define BIT_STOP_IDLE 13
`define BIT_WIDE 5
`define BIT_FAULT 4
`define BIT_TSEL 3
`define DISABLE_LSB 16
`define UNIT_INDEX 3'h0
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define IRQ_MATCH 0
`define IRQ_FAULT 1
`endif

/* inc/oc_pwm_pkg.sv */
// Types of the output compare unit
package oc_pwm_pkg;
    typedef enum logic [2:0] {
        MODE_OFF, MODE_RISE, MODE_FALL, MODE_TOGGLE,
        MODE_SINGLE, MODE_CONT, MODE_PWM, MODE_PWM_FAULT
    } mode_type;
    typedef struct packed {
        logic on;
        logic stopIdle;
        logic wide;
        logic timerSel;
        mode_type mode;
    } ctrl_type;
    typedef struct packed {
        logic [31:0] timer2;
        logic [31:0] timer3;
        logic idle;
        logic fault;
    } count_in_type;
endpackage

/* rtl/oc_compare_core.sv */
// Compare and pin engine of the output compare unit
`timescale 1ns/100ps
`include "oc_pwm_cfg.svh"
module oc_compare_core
    import oc_pwm_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire ctrl_type ctrl,
    input wire logic run,
    input wire count_in_type cnt,
    input wire logic [31:0] primary,
    input wire logic [31:0] secondary,
    input wire logic faultClr,
    output logic pin,
    output logic fault,
    output logic matchPulse
);
    typedef struct packed {
        logic pin;
        logic fault;
        logic done;
        logic match;
        mode_type lastMode;
        logic lastOn;
    } core_type;
    core_type s_q, s_d;
    logic [31:0] count;
    logic hitP, hitS, restart;
    always_comb begin
        count = ctrl.timerSel ? cnt.timer3 : cnt.timer2;
        if (ctrl.wide) begin
            hitP = count == primary;
            hitS = count == secondary;
        end else begin
            hitP = count[15:0] == primary[15:0];
            hitS = count[15:0] == secondary[15:0];
        end
        restart = ctrl.mode != s_q.lastMode || !s_q.lastOn;
        s_d = s_q;
        s_d.match = 1'b0;
        s_d.lastMode = ctrl.mode;
        s_d.lastOn = run;
        if (ctrl.mode != MODE_PWM_FAULT) begin
            s_d.fault = 1'b0;
        end else if (cnt.fault) begin
            s_d.fault = 1'b1;
        end else if (faultClr) begin
            s_d.fault = 1'b0;
        end
        if (!ctrl.on) begin
            s_d.pin = 1'b0;
            s_d.lastOn = 1'b0;
        end else if (run) begin
            s_d.match = hitP && ctrl.mode != MODE_OFF;
            case (ctrl.mode)
                MODE_OFF: s_d.pin = 1'b0;
                MODE_RISE: s_d.pin = restart ? 1'b0 : (s_q.pin | hitP);
                MODE_FALL: s_d.pin = restart ? 1'b1 : (s_q.pin & ~hitP);
                MODE_TOGGLE: s_d.pin = restart ? 1'b0 : (s_q.pin ^ hitP);
                MODE_SINGLE: begin
                    if (restart) begin
                        s_d.pin = 1'b0;
                        s_d.done = 1'b0;
                    end else if (hitS && s_q.pin) begin
                        s_d.pin = 1'b0;
                        s_d.done = 1'b1;
                    end else if (hitP && !s_q.done) begin
                        s_d.pin = 1'b1;
                    end
                end
                MODE_CONT: begin
                    if (restart) begin
                        s_d.pin = 1'b0;
                    end else if (hitS) begin
                        s_d.pin = 1'b0;
                    end else if (hitP) begin
                        s_d.pin = 1'b1;
                    end
                end
                MODE_PWM, MODE_PWM_FAULT: begin
                    if (ctrl.mode == MODE_PWM_FAULT && (s_d.fault || cnt.fault)) begin
                        s_d.pin = 1'b0;
                    end else if (hitS) begin
                        s_d.pin = 1'b0;
                    end else if (hitP) begin
                        s_d.pin = 1'b1;
                    end
                end
                default: s_d.pin = 1'b0;
            endcase
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign pin = s_q.pin;
    assign fault = s_q.fault;
    assign matchPulse = s_q.match;
endmodule

/* test/oc_timer_source.sv */
// Timer count source model for the output compare unit
`timescale 1ns/100ps
module oc_timer_source
    import oc_pwm_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic idle,
    input wire logic fault,
    output count_in_type cnt
);
    logic [31:0] t2_q;
    logic [31:0] t3_q;
    // Timers run on in idle; only the unit itself may halt
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            t2_q <= 32'h0001_0100;
            t3_q <= 32'h7e5d_9000;
        end else begin
            t2_q <= t2_q + 32'h1;
            t3_q <= t3_q + 32'h1;
        end
    end
    assign cnt = '{t2_q, t3_q, idle, fault};
endmodule

/* test/oc_unit_properties.sv */
// Bus handshake properties of the output compare unit
`timescale 1ns/100ps
module oc_unit_checker(
    input wire logic clk,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] s_axi_rresp
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [4:0] arAddr_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) arAddr_q <= 5'h0;
        else if (s_axi_arvalid && s_axi_arready) arAddr_q <= s_axi_araddr;
    end
    ////////////////////
    sequence joint_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence read_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_answer: assert property (joint_taken |-> ##2 s_axi_bvalid) else $error("late write response");
    a_aw_blocked: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready) else $error("aw taken twice");
    a_w_blocked: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready) else $error("w taken twice");
    a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
    a_read_answer: assert property (read_taken |=> s_axi_rvalid) else $error("late read data");
    a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar open during read");
    a_read_resp: assert property (s_axi_rvalid && arAddr_q[1:0] == 2'h0 && arAddr_q != 5'h14
        |-> (arAddr_q > 5'h18) == (s_axi_rresp == 2'h2)) else $error("bad read response");
endmodule
bind output_compare_pwm_unit oc_unit_checker u_oc_unit_checker(.*);

/* test/tb.sv */
// Self-checking bench of the output compare unit
`timescale 1ns/100ps
module tb;
    import oc_pwm_pkg::*;
    logic clk = 0, rst = 1, idle = 0, fault = 0;
    logic [3:0] s_axi_awaddr = 0, s_axi_wstrb = 4'hf;
    logic [4:0] s_axi_araddr = 0, s_axi_awaddrHi = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd, base, d;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, compareOutputPin, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    count_in_type cnt;
    int failures = 0, checked = 0, cyc = 0;
    always #5 clk = ~clk;
    oc_timer_source u_oc_timer_source(.clk, .rst, .idle, .fault, .cnt);
    output_compare_pwm_unit u_output_compare_pwm_unit(.*);
    ////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("failures %0d checked %0d", failures, checked);
        if (failures == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        @(posedge clk);
        s_axi_awaddr <= a[3:0];
        s_axi_awaddrHi <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // No cycle count assumed; only the bench timeout ends a hung wait
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rdReg(input logic [4:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // Pin sampled well clear of edges, so pipeline delay cannot matter
    task automatic at(input logic [31:0] t, input logic s, input logic e);
        for (int n = 0; n < 3000; n++) begin
            @(posedge clk);
            if ((s ? cnt.timer3[15:0] : cnt.timer2[15:0]) == t[15:0]) break;
        end
        check({31'h0, compareOutputPin}, {31'h0, e});
    endtask
    task automatic runMode(input logic [15:0] c, input logic [2:0] e);
        logic [31:0] p;
        logic [31:0] q;
        base = c[3] ? cnt.timer3 : cnt.timer2;
        p = base + 32'h2d;
        q = base + 32'h4b;
        if (!c[5]) begin
            p[31:16] = 16'($urandom);
            q[31:16] = 16'($urandom);
        end
        wr(5'h00, 32'h0);
        wr(5'h04, p);
        wr(5'h08, q);
        wr(5'h00, {16'h0, c});
        at(base + 32'h1e, c[3], e[2]);
        at(base + 32'h3c, c[3], e[1]);
        at(base + 32'h5f, c[3], e[0]);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            stop_test;
        end
    end
    initial begin
        void'($urandom(32'h53aae5e6));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdReg(5'h00);
        check(rd, 32'h0);
        rdReg(5'h0c);
        check(rd, 32'h0);
        rdReg(5'h1c);
        check({30'h0, rsp}, 32'h2);
        wr(5'h1c, 32'h1);
        check({30'h0, rsp}, 32'h2);
        for (int i = 0; i < 4; i++) begin
            d = $urandom;
            wr(5'h00, d);
            rdReg(5'h00);
            check(rd, d & 32'ha02f);
        end
        runMode(16'h8001, 3'b011);
        runMode(16'h8022, 3'b100);
        runMode(16'h802b, 3'b011);
        runMode(16'h8004, 3'b010);
        runMode(16'h800d, 3'b010);
        runMode(16'h8026, 3'b010);
        runMode(16'h8007, 3'b010);
        runMode(16'h8000, 3'b000);
        runMode(16'h0001, 3'b000);
        idle <= 1'b1;
        runMode(16'ha001, 3'b000);
        runMode(16'h8001, 3'b011);
        idle <= 1'b0;
        wr(5'h18, 32'h2);
        wr(5'h00, 32'h8007);
        @(posedge clk) fault <= 1'b1;
        @(posedge clk) fault <= 1'b0;
        wr(5'h00, 32'h8007);
        rdReg(5'h00);
        check(rd, 32'h8017);
        check({31'h0, irq}, 32'h1);
        wr(5'h00, 32'h8006);
        @(posedge clk) fault <= 1'b1;
        @(posedge clk) fault <= 1'b0;
        rdReg(5'h00);
        check(rd, 32'h8006);
        wr(5'h18, 32'h0);
        rdReg(5'h10);
        check(rd & 32'h2, 32'h2);
        check({31'h0, irq}, 32'h0);
        wr(5'h18, 32'h2);
        wr(5'h14, 32'h2);
        rdReg(5'h10);
        check(rd & 32'h2, 32'h0);
        check({31'h0, irq}, 32'h0);
        wr(5'h0c, 32'h001e_0000);
        wr(5'h00, 32'h8003);
        rdReg(5'h00);
        check(rd, 32'h8003);
        wr(5'h00, 32'h0);
        wr(5'h0c, 32'hffff_ffff);
        rdReg(5'h0c);
        check(rd, 32'h001f_0000);
        wr(5'h00, 32'h8003);
        wr(5'h0c, 32'h0);
        rdReg(5'h00);
        check(rd, 32'h0);
        stop_test;
    end
endmodule
